// file: tb/cfb_chb_taps6to9_assertions.sv
// Port checker for the channel-B tap 6..9 coefficient bank
`timescale 1ns/1ps
`default_nettype none
module cfb_chb_assertions (
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic [15:0]		s_axi_awaddr,
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic [31:0]		s_axi_wdata,
	input wire logic [3:0]		s_axi_wstrb,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic [1:0]		s_axi_bresp,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_bready,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic [31:0]		s_axi_rdata,
	input wire logic		s_axi_rvalid,
	input wire logic		s_axi_rready,
	input wire logic		m_psum_valid,
	input wire logic		m_psum_ready,
	input wire logic signed [25:0]	m_psum_data,
	input wire cfb_pkg::cfb_taps_t	eq_taps,
	input wire logic		dual_mode
);
	// One clock domain, synchronous reset disables every check
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	// Both write channels taken at one edge, at that same edge a full low-half write to one address
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_tap_wr(logic [15:0] a);
		s_wr_take ##0 (s_axi_awaddr == a && s_axi_wstrb[1:0] == 2'h3);
	endsequence
	// The datapath sees the written field, sign bit kept, once the response is up
	property p_commit(logic [15:0] a, logic [11:0] f);
		s_tap_wr(a) |-> ##2 (f == $past(s_axi_wdata[11:0], 2));
	endproperty
	////////////////////////////////////////
	a_write_answer: assert property (s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_msb_clear: assert property (s_axi_rvalid |-> !s_axi_rdata[11] && s_axi_rdata[31:16] == 16'h0)
		else $error("readback msb or upper half set");
	a_reset_taps_zero: assert property ($rose(aresetn) |-> eq_taps == '0 && !dual_mode)
		else $error("taps not cleared by reset");
	a_tap6_commit: assert property (p_commit(cfb_pkg::TAP_ADDR[0], eq_taps.tap6))
		else $error("tap6 weight not updated");
	a_tap7_commit: assert property (p_commit(cfb_pkg::TAP_ADDR[1], eq_taps.tap7))
		else $error("tap7 weight not updated");
	a_tap8_commit: assert property (p_commit(cfb_pkg::TAP_ADDR[2], eq_taps.tap8))
		else $error("tap8 weight not updated");
	a_tap9_commit: assert property (p_commit(cfb_pkg::TAP_ADDR[3], eq_taps.tap9))
		else $error("tap9 weight not updated");
	a_single_psum_zero: assert property ((!dual_mode)[*3] ##1 $rose(m_psum_valid) |-> m_psum_data == '0)
		else $error("psum nonzero outside dual mode");
	a_psum_hold: assert property (m_psum_valid && !m_psum_ready |=> m_psum_valid && $stable(m_psum_data))
		else $error("psum dropped while stalled");
endmodule
bind cfb_chb_taps6to9 cfb_chb_assertions i_cfb_chb_assertions (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .m_psum_valid, .m_psum_ready, .m_psum_data, .eq_taps, .dual_mode);
`default_nettype wire

// file: tb/cfb_chb_taps6to9_bench.sv
// Self-checking bench for the channel-B tap 6..9 coefficient bank
`timescale 1ns/1ps
`default_nettype none
module cfb_chb_taps6to9_bench;
	logic			aclk;
	logic			aresetn = 1'b0;
	logic [15:0]		s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]		s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]		s_axi_wstrb = 4'hF;
	logic [1:0]		s_axi_bresp, s_axi_rresp;
	logic			s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic			s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic			s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic			s_sample_valid = 1'b0, s_sample_ready, m_psum_valid, m_psum_ready = 1'b0;
	logic signed [11:0]	s_sample_data = '0;
	logic signed [25:0]	m_psum_data;
	cfb_pkg::cfb_taps_t	eq_taps;
	logic			dual_mode, saw_full;
	logic [25:0]		exp_q[$], got_q[$];
	int			mismatches, comparisons, cycles, hist[9], coef[4];
	// Sign bit set on tap6 and tap8 so the readback defect and signed weights both show
	localparam logic [15:0] VALS [4] = '{16'hA9C5, 16'h37FF, 16'hC800, 16'h0001};

	cfb_chb_taps6to9 i_cfb_chb_taps6to9 (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_sample_valid, .s_sample_ready,
		.s_sample_data, .m_psum_valid, .m_psum_ready, .m_psum_data, .eq_taps, .dual_mode);
	////////////////////////////////////////
	// 100 ns clock; watchdog cuts a hang short; collector and full flag watch the stream
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	always @(posedge aclk) if (aresetn && m_psum_valid && m_psum_ready) got_q.push_back(m_psum_data);
	always @(posedge aclk) if (aresetn && !s_sample_ready) saw_full <= 1'b1;
	////////////////////////////////////////
	task automatic tally_and_finish();
		if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	// History is cleared with the design so the model stays aligned
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		hist = '{default: 0};
	endtask
	// Both write channels offered together, each released once taken
	task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	////////////////////////////////////////
	// All four coefficients, the weights and the mode read zero after reset
	task automatic t_reset_regs();
		logic [1:0] r;
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			axi_read(cfb_pkg::TAP_ADDR[i], d, r);
			chk("tap_reset", 32'h0, d);
		end
		chk("weights_reset", 32'h0, eq_taps[31:0] | 32'(eq_taps[47:32]));
		chk("mode_reset", 32'h0, 32'(dual_mode));
	endtask
	// Upper word half ignored, spare bits kept, msb lost only in the read view
	task automatic t_tap_rw();
		logic [1:0] r;
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			axi_write(cfb_pkg::TAP_ADDR[i], {16'hFFFF, VALS[i]}, r);
			chk("tap_wr_resp", 32'(cfb_pkg::RESP_OKAY), 32'(r));
			chk("tap_weight", 32'(VALS[i][11:0]), 32'(eq_taps[12*i +: 12]));
			coef[i] = $signed(VALS[i][11:0]);
		end
		for (int i = 0; i < 4; i++) begin
			axi_read(cfb_pkg::TAP_ADDR[i], d, r);
			chk("tap_readback", 32'(VALS[i] & 16'hF7FF), d);
		end
	endtask
	// The gap between tap6 and tap7 is refused and disturbs nothing
	task automatic t_unmapped();
		logic [1:0] r;
		logic [31:0] d;
		axi_write(16'h1150, 32'h0000_0123, r);
		chk("gap_wr_resp", 32'(cfb_pkg::RESP_SLVERR), 32'(r));
		chk("gap_tap6", 32'(VALS[0][11:0]), 32'(eq_taps[11:0]));
		axi_read(16'h1150, d, r);
		chk("gap_rd_resp", 32'(cfb_pkg::RESP_SLVERR), 32'(r));
		chk("gap_rd_data", 32'h0, d);
		// Byte lane 1 alone: the low byte of tap7 keeps its old value
		s_axi_wstrb <= 4'h2;
		axi_write(cfb_pkg::TAP_ADDR[1], 32'h0000_5A00, r);
		s_axi_wstrb <= 4'hF;
		chk("lane_weight", 32'h0AFF, 32'(eq_taps[23:12]));
		axi_read(cfb_pkg::TAP_ADDR[1], d, r);
		chk("lane_readback", 32'h52FF, d);
		coef[1] = $signed(12'hAFF);
	endtask
	// Twelve samples through the bank; stalling the output fills the FIFO until it refuses
	task automatic t_stream(input logic d_on, input logic stall);
		logic [1:0] r;
		int x;
		int e;
		int w;
		logic [31:0] d;
		axi_write(cfb_pkg::ADDR_CTRL, 32'(d_on), r);
		chk("mode", 32'(d_on), 32'(dual_mode));
		exp_q.delete();
		got_q.delete();
		saw_full = 1'b0;
		m_psum_ready <= !stall;
		if (stall) fork
			begin
				repeat (40) @(posedge aclk);
				m_psum_ready <= 1'b1;
			end
		join_none
		for (int k = 0; k < 12; k++) begin
			x = ((k * 1237) % 4096) - 2048;
			s_sample_valid <= 1'b1;
			s_sample_data <= 12'(x);
			do @(posedge aclk); while (!s_sample_ready);
			for (int j = 8; j > 0; j--) hist[j] = hist[j - 1];
			hist[0] = x;
			e = d_on ? coef[0]*hist[5] + coef[1]*hist[6] + coef[2]*hist[7] + coef[3]*hist[8] : 0;
			exp_q.push_back(26'(e));
		end
		s_sample_valid <= 1'b0;
		w = 0;
		while (got_q.size() < 12 && w < 300) begin
			@(posedge aclk);
			w++;
		end
		chk("psum_count", 32'h0C, 32'(got_q.size()));
		for (int k = 0; k < got_q.size(); k++) chk("psum", 32'(exp_q[k]), 32'(got_q[k]));
		if (stall) chk("fifo_refused", 32'h1, 32'(saw_full));
		axi_read(cfb_pkg::ADDR_CTRL, d, r);
		chk("mode_read", 32'(d_on), d);
		axi_read(cfb_pkg::ADDR_STAT, d, r);
		chk("status_idle", 32'h0, d);
	endtask
	// A reset in mid-run clears coefficients that were programmed
	task automatic t_mid_reset();
		logic [1:0] r;
		logic [31:0] d;
		do_reset();
		t_reset_regs();
		axi_read(cfb_pkg::TAP_ADDR[3], d, r);
		chk("tap9_after_reset", 32'h0, d);
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		@(posedge aclk);
		do_reset();
		t_reset_regs();
		t_tap_rw();
		t_unmapped();
		t_stream(1'b0, 1'b0);
		t_stream(1'b1, 1'b1);
		t_mid_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: verilog/cfb_chb_taps6to9.sv
// Channel-B equalizer tap 6..9 coefficient bank with AXI4-Lite access and partial sum
//
// Behaviour
// - Coefficient bits 11:0 are signed two's complement
// - Register 0x453 weights tap six, dual mode
// - Register 0x455 weights tap seven, dual mode
// - Register 0x457 weights tap eight, dual mode
// - Register 0x459 weights tap nine, dual mode
// - Readback forces coefficient MSB to zero
// - All four coefficients reset to zero
// - Nine taps; centre tap 18 bits, others 12
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module cfb_chb_taps6to9 (
	input  wire logic                               aclk,
	input  wire logic                               aresetn,
	// AXI4-Lite slave
	input  wire logic [cfb_pkg::ADDR_W-1:0]         s_axi_awaddr,
	input  wire logic                               s_axi_awvalid,
	output var  logic                               s_axi_awready,
	input  wire logic [cfb_pkg::DATA_W-1:0]         s_axi_wdata,
	input  wire logic [cfb_pkg::STRB_W-1:0]         s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output var  logic                               s_axi_wready,
	output var  logic [1:0]                         s_axi_bresp,
	output var  logic                               s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [cfb_pkg::ADDR_W-1:0]         s_axi_araddr,
	input  wire logic                               s_axi_arvalid,
	output var  logic                               s_axi_arready,
	output var  logic [cfb_pkg::DATA_W-1:0]         s_axi_rdata,
	output var  logic [1:0]                         s_axi_rresp,
	output var  logic                               s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	// Channel-B sample stream in
	input  wire logic                               s_sample_valid,
	output var  logic                               s_sample_ready,
	input  wire logic signed [cfb_pkg::SAMPLE_W-1:0] s_sample_data,
	// Partial sum of taps 6..9 out
	output var  logic                               m_psum_valid,
	input  wire logic                               m_psum_ready,
	output var  logic signed [cfb_pkg::PSUM_W-1:0]  m_psum_data,
	// Tap weights and mode to the filter datapath
	output var  cfb_pkg::cfb_taps_t                 eq_taps,
	output var  logic                               dual_mode
);
	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	cfb_pkg::cfb_coef_reg_t coef_r [cfb_pkg::N_BANK];
	logic                   dual_mode_r;

	logic                              awready_r;
	logic                              wready_r;
	logic                              bvalid_r;
	logic [1:0]                        bresp_r;
	logic [cfb_pkg::ADDR_W-1:0]        awaddr_r;
	logic [cfb_pkg::DATA_W-1:0]        wdata_r;
	logic [cfb_pkg::STRB_W-1:0]        wstrb_r;
	logic                              arready_r;
	logic                              rvalid_r;
	logic [cfb_pkg::DATA_W-1:0]        rdata_r;
	logic [1:0]                        rresp_r;

	logic                              aw_fire;
	logic                              w_fire;
	logic                              wr_go;
	logic                              b_done;
	logic                              ar_fire;
	logic                              r_done;
	logic [cfb_pkg::N_BANK-1:0]        wr_hit;
	logic [cfb_pkg::N_BANK-1:0]        rd_hit;
	logic                              wr_ctrl;
	logic                              rd_ctrl;
	logic                              rd_stat;
	logic                              wr_known;
	logic                              rd_known;
	logic [cfb_pkg::REG_W-1:0]         wr_merge [cfb_pkg::N_BANK];
	logic [cfb_pkg::REG_W-1:0]         rd_view [cfb_pkg::N_BANK];
	logic [cfb_pkg::DATA_W-1:0]        rd_taps;
	logic [cfb_pkg::DATA_W-1:0]        rd_word;
	logic [cfb_pkg::DATA_W-1:0]        ctrl_word;
	logic [cfb_pkg::DATA_W-1:0]        stat_word;

	logic                              fifo_valid;
	logic                              fifo_pop;
	logic signed [cfb_pkg::SAMPLE_W-1:0] fifo_data;
	logic [cfb_pkg::FIFO_LVL_W-1:0]    fifo_level;
	logic signed [cfb_pkg::SAMPLE_W-1:0] hist_r [cfb_pkg::HIST_N];
	logic signed [cfb_pkg::PROD_W-1:0] prod [cfb_pkg::N_BANK];
	logic signed [cfb_pkg::PSUM_W-1:0] psum_nxt;
	logic                              psum_valid_r;
	logic signed [cfb_pkg::PSUM_W-1:0] psum_r;

	////////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are taken in either order

	assign aw_fire = s_axi_awvalid & awready_r;
	assign w_fire  = s_axi_wvalid & wready_r;
	// The master may hold either half back; nothing commits until both are in
	// Both halves held and no response pending: commit the write
	assign wr_go   = ~awready_r & ~wready_r & ~bvalid_r;
	assign b_done  = bvalid_r & s_axi_bready;

	// Address and data holding latches
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= '0;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else begin
			if (aw_fire) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	// Channel readies close on capture and reopen when the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= cfb_pkg::RESP_OKAY;
		end else begin
			if (aw_fire) begin
				awready_r <= 1'b0;
			end
			if (w_fire) begin
				wready_r <= 1'b0;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_known ? cfb_pkg::RESP_OKAY : cfb_pkg::RESP_SLVERR;
			end
			if (b_done) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address decode; only whole aligned words match

	genvar gi;
	generate
		for (gi = 0; gi < cfb_pkg::N_BANK; gi++) begin : g_dec
			assign wr_hit[gi] = (awaddr_r == cfb_pkg::TAP_ADDR[gi]);
			assign rd_hit[gi] = (s_axi_araddr == cfb_pkg::TAP_ADDR[gi]);
			// Byte lanes 0 and 1 cover the 16-bit register; upper lanes are ignored
			assign wr_merge[gi] = {
				wstrb_r[1] ? wdata_r[15:8] : coef_r[gi][15:8],
				wstrb_r[0] ? wdata_r[7:0]  : coef_r[gi][7:0]
			};
			// Readback returns spare bits as written but the sign bit as zero
			assign rd_view[gi] = {coef_r[gi].rsvd, 1'b0,
				coef_r[gi].coef[cfb_pkg::COEF_MSB-1:0]};
		end
	endgenerate

	assign wr_ctrl  = (awaddr_r == cfb_pkg::ADDR_CTRL);
	assign rd_ctrl  = (s_axi_araddr == cfb_pkg::ADDR_CTRL);
	assign rd_stat  = (s_axi_araddr == cfb_pkg::ADDR_STAT);
	assign wr_known = (|wr_hit) | wr_ctrl;
	assign rd_known = (|rd_hit) | rd_ctrl | rd_stat;

	////////////////////////////////////////////////////////////////////////////////
	// Coefficient and control storage

	// Coefficients start at zero so these taps add nothing until programmed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < cfb_pkg::N_BANK; i++) begin
				coef_r[i] <= cfb_pkg::COEF_REG_RST;
			end
		end else if (wr_go) begin
			for (int i = 0; i < cfb_pkg::N_BANK; i++) begin
				if (wr_hit[i]) begin
					coef_r[i] <= wr_merge[i];
				end
			end
		end
	end

	// Converter mode; the bank is only applied in dual-channel operation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dual_mode_r <= cfb_pkg::CTRL_DUAL_RST;
		end else if (wr_go && wr_ctrl && wstrb_r[0]) begin
			dual_mode_r <= wdata_r[cfb_pkg::CTRL_DUAL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel: one cycle from address to data

	assign ar_fire = s_axi_arvalid & arready_r;
	assign r_done  = rvalid_r & s_axi_rready;

	// Registers are 16 bits wide; upper bits of the word read as zero
	always_comb begin
		rd_taps = '0;
		for (int i = 0; i < cfb_pkg::N_BANK; i++) begin
			if (rd_hit[i]) begin
				rd_taps = cfb_pkg::DATA_W'(rd_view[i]);
			end
		end
	end

	// Control word carries the mode bit at its own position
	always_comb begin
		ctrl_word = '0;
		ctrl_word[cfb_pkg::CTRL_DUAL_BIT] = dual_mode_r;
	end

	// Status word: FIFO fill level and the waiting-sum flag at their own positions
	always_comb begin
		stat_word = '0;
		stat_word[cfb_pkg::STAT_LVL_LSB +: cfb_pkg::FIFO_LVL_W] = fifo_level;
		stat_word[cfb_pkg::STAT_OVLD_BIT] = psum_valid_r;
	end

	// Status shows FIFO fill and whether a partial sum is waiting
	assign rd_word = rd_ctrl ? ctrl_word :
		rd_stat ? stat_word :
		rd_taps;

	// Read response register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= cfb_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_word;
			rresp_r   <= rd_known ? cfb_pkg::RESP_OKAY : cfb_pkg::RESP_SLVERR;
		end else if (r_done) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample path: the FIFO absorbs bursts while the sum output is stalled

	cfb_fifo #(
		.WIDTH (cfb_pkg::SAMPLE_W),
		.DEPTH (cfb_pkg::FIFO_DEPTH),
		.LVL_W (cfb_pkg::FIFO_LVL_W)
	) i_cfb_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (s_sample_valid),
		.in_ready  (s_sample_ready),
		.in_data   (s_sample_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data),
		.level     (fifo_level)
	);

	// Pull a sample only when the output slot is free or being emptied
	// A stalled consumer thus back-pressures the sample source through the FIFO
	assign fifo_pop = fifo_valid & (~psum_valid_r | m_psum_ready);

	// History of the previous eight samples; taps six to nine use the oldest four
	// Reset clears it so the first sums after reset see silence, not stale data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < cfb_pkg::HIST_N; i++) begin
				hist_r[i] <= '0;
			end
		end else if (fifo_pop) begin
			hist_r[0] <= fifo_data;
			for (int i = 1; i < cfb_pkg::HIST_N; i++) begin
				hist_r[i] <= hist_r[i-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tap products; tap k weights the sample k-1 places back

	generate
		for (gi = 0; gi < cfb_pkg::N_BANK; gi++) begin : g_tap
			// Both operands signed so negative weights scale correctly
			assign prod[gi] = coef_r[gi].coef *
				hist_r[cfb_pkg::FIRST_TAP - 2 + gi];
		end
	endgenerate

	// Partial sum is two bits wider than one product: four terms cannot overflow.
	// The 18-bit centre tap lives in the other bank, so it is not summed here.
	always_comb begin
		psum_nxt = '0;
		if (dual_mode_r) begin
			psum_nxt = cfb_pkg::PSUM_W'(prod[0])
				+ cfb_pkg::PSUM_W'(prod[1])
				+ cfb_pkg::PSUM_W'(prod[2])
				+ cfb_pkg::PSUM_W'(prod[3]);
		end
	end

	// Output slot; holds its value until the consumer takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			psum_valid_r <= 1'b0;
			psum_r       <= '0;
		end else if (fifo_pop) begin
			psum_valid_r <= 1'b1;
			psum_r       <= psum_nxt;
		end else if (m_psum_ready) begin
			psum_valid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all taken straight from flops

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign m_psum_valid  = psum_valid_r;
	assign m_psum_data   = psum_r;
	assign dual_mode     = dual_mode_r;
	// Full signed weights, sign bit intact, go to the datapath
	assign eq_taps.tap6  = coef_r[0].coef;
	assign eq_taps.tap7  = coef_r[1].coef;
	assign eq_taps.tap8  = coef_r[2].coef;
	assign eq_taps.tap9  = coef_r[3].coef;
endmodule
`default_nettype wire

// file: verilog/cfb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cfb_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8,
	parameter int LVL_W = 4
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data,
	output var  logic [LVL_W-1:0] level
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [LVL_W-1:0] count_r;
	logic [LVL_W-1:0] count_nxt;
	logic             in_ready_r;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////////////
	// Handshakes; ready is a flop so the source sees no combinational path
	assign push      = in_valid & in_ready_r;
	assign pop       = out_valid & out_ready;
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];
	assign in_ready  = in_ready_r;
	assign level     = count_r;
	assign count_nxt = LVL_W'(count_r + LVL_W'(push) - LVL_W'(pop));

	////////////////////////////////////////////////////////////////////////////////
	// Storage needs no reset; only valid words are ever read
	always_ff @(posedge aclk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// Pointers, fill level and space flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r   <= '0;
			rd_ptr_r   <= '0;
			count_r    <= '0;
			in_ready_r <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= PTR_W'(wr_ptr_r + 1'b1);
			end
			if (pop) begin
				rd_ptr_r <= PTR_W'(rd_ptr_r + 1'b1);
			end
			count_r    <= count_nxt;
			in_ready_r <= (count_nxt < LVL_W'(DEPTH));
		end
	end
endmodule
`default_nettype wire

// file: verilog/cfb_pkg.sv
// Shared constants and types for the channel-B equalizer tap 6..9 coefficient bank
`default_nettype none
package cfb_pkg;
	// Bus geometry
	localparam int ADDR_W     = 16;
	localparam int DATA_W     = 32;
	localparam int STRB_W     = DATA_W / 8;
	localparam int REG_W      = 16;
	// Coefficient layout: signed field in the low bits, spare bits above
	localparam int COEF_W     = 12;
	localparam int RSVD_W     = REG_W - COEF_W;
	localparam int COEF_MSB   = COEF_W - 1;
	localparam int CENTRE_W   = 18;
	localparam int N_TAPS     = 9;
	localparam int N_BANK     = 4;
	localparam int FIRST_TAP  = 6;
	// Sample stream and partial sum widths
	localparam int SAMPLE_W   = 12;
	localparam int PROD_W     = COEF_W + SAMPLE_W;
	localparam int PSUM_W     = PROD_W + 2;
	localparam int HIST_N     = N_TAPS - 1;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LVL_W = 4;
	// Register indices; the byte address is four times the index
	localparam logic [11:0] IDX_TAP6 = 12'h453;
	localparam logic [11:0] IDX_TAP7 = 12'h455;
	localparam logic [11:0] IDX_TAP8 = 12'h457;
	localparam logic [11:0] IDX_TAP9 = 12'h459;
	localparam logic [11:0] IDX_CTRL = 12'h460;
	localparam logic [11:0] IDX_STAT = 12'h461;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(IDX_CTRL * 4);
	localparam logic [ADDR_W-1:0] ADDR_STAT = ADDR_W'(IDX_STAT * 4);
	localparam logic [ADDR_W-1:0] TAP_ADDR [N_BANK] = '{
		ADDR_W'(IDX_TAP6 * 4),
		ADDR_W'(IDX_TAP7 * 4),
		ADDR_W'(IDX_TAP8 * 4),
		ADDR_W'(IDX_TAP9 * 4)
	};
	// Control and status fields
	localparam int CTRL_DUAL_BIT   = 0;
	localparam logic CTRL_DUAL_RST = 1'h0;
	localparam int STAT_LVL_LSB    = 0;
	localparam int STAT_OVLD_BIT   = 4;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// One coefficient register as stored
	typedef struct packed {
		logic [RSVD_W-1:0]        rsvd;
		logic signed [COEF_W-1:0] coef;
	} cfb_coef_reg_t;
	localparam cfb_coef_reg_t COEF_REG_RST = '{rsvd: 4'h0, coef: 12'h000};
	// Tap weights handed to the filter datapath
	typedef struct packed {
		logic signed [COEF_W-1:0] tap9;
		logic signed [COEF_W-1:0] tap8;
		logic signed [COEF_W-1:0] tap7;
		logic signed [COEF_W-1:0] tap6;
	} cfb_taps_t;
endpackage
`default_nettype wire
